// ==== design/tsie_top.sv ====
// ----------------------------------------------------------------------------
// per-channel status flags and interrupt enables of a five-channel timer
// ----------------------------------------------------------------------------
// assumes counter values, mode levels and match events come from timer logic
// on clk; the register port is a same-clock master with one-cycle strobes.
//
// Summary of operation
// R1 - in channels 0, 3 and 4 enable C passes match flag C to request C, in channels 1 and 2 it reads 0.
// R2 - in every channel enable B at bit 1 passes match flag B to request B only when it is 1.
// R3 - in every channel enable A at bit 0 passes match flag A to request A only when it is 1.
// R4 - each of the five channels has its own 8-bit status register.
// R5 - in channels 1 to 4 status bit 7 is read-only, shows the count direction (1 up) and resets to 1.
// R6 - in channel 0 status bit 7 always reads 1 and software writes only 1 to it.
// R7 - status bit 6 always reads 1 in every channel and software writes only 1 to it.
// R8 - in channels 1 and 2 in phase counting mode the underflow flag at bit 5 sets on a 0000 to ffff wrap.
// R9 - in channels 0, 3 and 4 status bit 5 reads 0 and software writes only 0 to it.
// R10 - the underflow flag clears only on a write of 0 after it was read as 1, a written 1 does nothing.
// R11 - the overflow flag at bit 4 sets whenever the counter wraps from ffff to 0000.
// R12 - in channel 4 complementary pwm mode the overflow flag also sets on a step from 0001 to 0000.
// R13 - the overflow flag clears on a write of 0 after it was read as 1, flags accept only 0 for clearing.
// R14 - channel 4 overflow also clears when its interrupt starts the transfer controller with clear-disable 0.
// R15 - match flag B sets on a compare match or an input capture into compare_capture_b.
// R16 - each request is high in the cycle after its flag and its enable are both 1, and low otherwise.
// R17 - a set and a clear of a flag in the same cycle leave the flag set.
module tsie_top
    import tsie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    input wire logic [NUM_CH-1:0][CW-1:0] channel_counter,
    input wire logic [NUM_CH-1:0] count_up,
    input wire logic [2:1] phase_count_mode,
    input wire logic cmp_pwm_mode,
    input wire logic [NUM_CH-1:0] match_a_event,
    input wire logic [NUM_CH-1:0] match_b_event,
    input wire logic [NUM_CH-1:0] match_c_event,
    input wire logic [NUM_CH-1:0] xfer_ack_a,
    input wire logic [NUM_CH-1:0] xfer_ack_b,
    input wire logic [NUM_CH-1:0] xfer_ack_c,
    input wire logic xfer_ack_ovf,
    input wire logic transfer_clear_disable,
    output logic [NUM_CH-1:0] match_a_irq,
    output logic [NUM_CH-1:0] match_b_irq,
    output logic [NUM_CH-1:0] match_c_irq,
    output logic overflow_irq,
    output logic irq
);

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    logic [NUM_CH-1:0][CW-1:0] cnt_prev_ff;
    logic cnt_valid_ff;
    logic [NUM_CH-1:0] dir_ff;
    logic [NUM_CH-1:0] match_a_irq_enable;
    logic [NUM_CH-1:0] match_b_irq_enable;
    logic [NUM_CH-1:0] match_c_irq_enable;
    logic [NUM_CH-1:0] match_a_flag;
    logic [NUM_CH-1:0] match_b_flag;
    logic [NUM_CH-1:0] match_c_flag;
    logic [NUM_CH-1:0] overflow_flag;
    logic [NUM_CH-1:0] underflow_flag;
    logic [NUM_CH-1:0] ovf_set;
    logic [NUM_CH-1:0] unf_set;
    logic [NUM_CH-1:0] wr_stat;
    logic [NUM_CH-1:0] rd_stat;
    logic [NUM_CH-1:0] wr_en;
    logic [NUM_CH-1:0][DW-1:0] status_view;
    logic [NUM_CH-1:0][DW-1:0] enable_view;
    logic [EVT_W-1:0] evt_stat;
    logic [EVT_W-1:0] evt_mask;
    logic evt_irq_ff;
    logic ovf4_ack_clr;
    logic [DW-1:0] nxt_rdata;
    logic [DW-1:0] rdata_ff;
    logic [NUM_CH-1:0] match_a_irq_ff;
    logic [NUM_CH-1:0] match_b_irq_ff;
    logic [NUM_CH-1:0] match_c_irq_ff;
    logic overflow_irq_ff;

    // ------------------------------------------------------------------------
    // counter history for wrap detection
    // ------------------------------------------------------------------------
    // the first sample after reset has no history, so no wrap is reported
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_prev_ff <= '0;
            cnt_valid_ff <= 1'b0;
        end else begin
            cnt_prev_ff <= channel_counter;
            cnt_valid_ff <= 1'b1;
        end
    end

    // count direction, ch0 holds its reset value since bit 7 is fixed there
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_ff <= {NUM_CH{RST_DIR}};
        end else begin
            dir_ff <= {count_up[NUM_CH-1:1], RST_DIR}; // R5
        end
    end

    // transfer controller takes over the ch4 overflow clear unless disabled
    assign ovf4_ack_clr = xfer_ack_ovf && !transfer_clear_disable; // R14

    // ------------------------------------------------------------------------
    // per-channel flags, enables and register views
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam bit HAS_C = (i == 0) || (i == 3) || (i == 4);
        localparam bit HAS_UNF = (i == 1) || (i == 2);
        localparam logic [AW-1:0] A_STAT = OFS_STATUS + AW'(i);
        localparam logic [AW-1:0] A_EN = OFS_ENABLE + AW'(i);

        // strobes decoded per channel register
        assign wr_stat[i] = reg_wr && (reg_addr == A_STAT); // R4
        assign rd_stat[i] = reg_rd && (reg_addr == A_STAT);
        assign wr_en[i] = reg_wr && (reg_addr == A_EN);

        // wrap detection on the sampled counter
        if (i == 4) begin : g_ovf4
            assign ovf_set[i] = cnt_valid_ff && (((cnt_prev_ff[i] == CNT_MAX) && (channel_counter[i] == CNT_ZERO)) // R11
                || (cmp_pwm_mode && (cnt_prev_ff[i] == CNT_ONE) && (channel_counter[i] == CNT_ZERO))); // R12
        end else begin : g_ovf
            assign ovf_set[i] = cnt_valid_ff && (cnt_prev_ff[i] == CNT_MAX) && (channel_counter[i] == CNT_ZERO); // R11
        end
        if (HAS_UNF) begin : g_unf
            assign unf_set[i] = cnt_valid_ff && phase_count_mode[i] && (cnt_prev_ff[i] == CNT_ZERO)
                && (channel_counter[i] == CNT_MAX); // R8
            tsie_flag u_unf (
                .clk(clk), .rst_n(rst_n), .set(unf_set[i]), .rd(rd_stat[i]), .wr(wr_stat[i]),
                .wbit(reg_wdata[BIT_UNF]), .ack_clr(1'b0), .flag_ff(underflow_flag[i])
            ); // R10
        end else begin : g_no_unf
            assign unf_set[i] = 1'b0;
            assign underflow_flag[i] = 1'b0; // R9
        end

        // overflow flag, ch4 also cleared by the transfer controller
        tsie_flag u_ovf (
            .clk(clk), .rst_n(rst_n), .set(ovf_set[i]), .rd(rd_stat[i]), .wr(wr_stat[i]),
            .wbit(reg_wdata[BIT_OVF]), .ack_clr((i == 4) ? ovf4_ack_clr : 1'b0), .flag_ff(overflow_flag[i])
        ); // R13

        // match flags A and B exist in every channel
        tsie_flag u_ma (
            .clk(clk), .rst_n(rst_n), .set(match_a_event[i]), .rd(rd_stat[i]), .wr(wr_stat[i]),
            .wbit(reg_wdata[BIT_MATCH_A]), .ack_clr(xfer_ack_a[i]), .flag_ff(match_a_flag[i])
        );
        tsie_flag u_mb (
            .clk(clk), .rst_n(rst_n), .set(match_b_event[i]), .rd(rd_stat[i]), .wr(wr_stat[i]),
            .wbit(reg_wdata[BIT_MATCH_B]), .ack_clr(xfer_ack_b[i]), .flag_ff(match_b_flag[i])
        ); // R15

        // match flag C and its enable only where the channel has register C
        if (HAS_C) begin : g_c
            tsie_flag u_mc (
                .clk(clk), .rst_n(rst_n), .set(match_c_event[i]), .rd(rd_stat[i]), .wr(wr_stat[i]),
                .wbit(reg_wdata[BIT_MATCH_C]), .ack_clr(xfer_ack_c[i]), .flag_ff(match_c_flag[i])
            );
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    match_c_irq_enable[i] <= RST_ENABLE;
                end else if (wr_en[i]) begin
                    match_c_irq_enable[i] <= reg_wdata[BIT_MATCH_C]; // R1
                end
            end
        end else begin : g_no_c
            assign match_c_flag[i] = 1'b0;
            assign match_c_irq_enable[i] = 1'b0; // R1
        end

        // enables A and B are plain read/write bits
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                match_a_irq_enable[i] <= RST_ENABLE;
                match_b_irq_enable[i] <= RST_ENABLE;
            end else if (wr_en[i]) begin
                match_a_irq_enable[i] <= reg_wdata[BIT_MATCH_A]; // R3
                match_b_irq_enable[i] <= reg_wdata[BIT_MATCH_B]; // R2
            end
        end

        // read views; bit 3 belongs to a flag outside this block and reads 0
        assign status_view[i] = {dir_ff[i], RST_RSV6, underflow_flag[i], overflow_flag[i], 1'b0,
            match_c_flag[i], match_b_flag[i], match_a_flag[i]}; // R6 R7
        assign enable_view[i] = {5'h00, match_c_irq_enable[i], match_b_irq_enable[i], match_a_irq_enable[i]};
    end

    // ------------------------------------------------------------------------
    // event status and level interrupt
    // ------------------------------------------------------------------------
    tsie_evt_irq u_evt (
        .clk(clk),
        .rst_n(rst_n),
        .evt({unf_set[2], unf_set[1], ovf_set}),
        .wr_stat(reg_wr && (reg_addr == OFS_EVT_STAT)),
        .wr_mask(reg_wr && (reg_addr == OFS_EVT_MASK)),
        .wdata(reg_wdata[EVT_W-1:0]),
        .stat_ff(evt_stat),
        .mask_ff(evt_mask),
        .irq_ff(evt_irq_ff)
    );

    // ------------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------------
    // read mux; unmapped addresses answer zero
    always_comb begin
        nxt_rdata = RST_RDATA;
        for (int k = 0; k < NUM_CH; k++) begin
            if (reg_addr == OFS_STATUS + AW'(k)) begin
                nxt_rdata = status_view[k];
            end
            if (reg_addr == OFS_ENABLE + AW'(k)) begin
                nxt_rdata = enable_view[k];
            end
        end
        if (reg_addr == OFS_EVT_STAT) begin
            nxt_rdata = {1'b0, evt_stat};
        end
        if (reg_addr == OFS_EVT_MASK) begin
            nxt_rdata = {1'b0, evt_mask};
        end
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= RST_RDATA;
        end else if (reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= RST_RDATA;
        end
    end

    // ------------------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------------------
    // registered gating costs one cycle of latency but keeps outputs glitch free
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            match_a_irq_ff <= '0;
            match_b_irq_ff <= '0;
            match_c_irq_ff <= '0;
            overflow_irq_ff <= 1'b0;
        end else begin
            match_a_irq_ff <= match_a_flag & match_a_irq_enable; // R3 R16
            match_b_irq_ff <= match_b_flag & match_b_irq_enable; // R2 R16
            match_c_irq_ff <= match_c_flag & match_c_irq_enable; // R1 R16
            overflow_irq_ff <= overflow_flag[4] && evt_mask[EVT_OVF_LSB + 4];
        end
    end

    assign reg_rdata = rdata_ff;
    assign match_a_irq = match_a_irq_ff;
    assign match_b_irq = match_b_irq_ff;
    assign match_c_irq = match_c_irq_ff;
    assign overflow_irq = overflow_irq_ff;
    assign irq = evt_irq_ff;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_irq_a_gate: assert property (match_a_irq == $past(match_a_flag & match_a_irq_enable)) // R3
        else $error("request A does not follow flag and enable");
    a_irq_b_gate: assert property (match_b_flag[0] && !match_b_irq_enable[0] |=> !match_b_irq[0]) // R2
        else $error("request B passed while disabled");
    a_irq_c_rsv: assert property (match_c_irq[2:1] == 2'b00 && enable_view[1][BIT_MATCH_C] == 1'b0) // R1
        else $error("channel 1 or 2 shows a C enable or request");
    a_irq_level: assert property (match_a_flag[3] && match_a_irq_enable[3] ##1 match_a_flag[3] && match_a_irq_enable[3]
        |-> match_a_irq[3]) // R16
        else $error("request A low while flag and enable are high");
    a_dir_read: assert property (rd_stat[1] |=> reg_rdata[BIT_DIR] == $past(count_up[1], 2)) // R5
        else $error("direction bit does not show the counter direction");
    a_ch0_fixed: assert property (rd_stat[0] |=> reg_rdata[BIT_DIR:BIT_RSV6] == 2'b11) // R6
        else $error("channel 0 bits 7 and 6 not read as one");
    a_rsv6_one: assert property (rd_stat[2] |=> reg_rdata[BIT_RSV6]) // R7
        else $error("bit 6 not read as one");
    a_rsv5_zero: assert property (rd_stat[3] |=> !reg_rdata[BIT_UNF]) // R9
        else $error("bit 5 not read as zero in channel 3");
    a_unf_wrap: assert property (cnt_valid_ff && phase_count_mode[1] && cnt_prev_ff[1] == CNT_ZERO
        && channel_counter[1] == CNT_MAX |=> underflow_flag[1]) // R8
        else $error("underflow wrap did not set the flag");
    a_unf_w1_keep: assert property (underflow_flag[1] && wr_stat[1] && reg_wdata[BIT_UNF] |=> underflow_flag[1]) // R10
        else $error("writing one cleared the underflow flag");
    a_ovf_wrap: assert property (cnt_valid_ff && cnt_prev_ff[0] == CNT_MAX && channel_counter[0] == CNT_ZERO
        |=> overflow_flag[0]) // R11
        else $error("overflow wrap did not set the flag");
    a_ovf_pwm: assert property (cnt_valid_ff && cmp_pwm_mode && cnt_prev_ff[4] == CNT_ONE
        && channel_counter[4] == CNT_ZERO |=> overflow_flag[4]) // R12
        else $error("complementary pwm step did not set the overflow flag");
    a_ovf_clear: assert property (rd_stat[2] && overflow_flag[2] ##1 wr_stat[2] && !reg_wdata[BIT_OVF]
        && !ovf_set[2] |=> !overflow_flag[2]) // R13
        else $error("read one then write zero did not clear overflow");
    a_ovf_ack: assert property (ovf4_ack_clr && !ovf_set[4] |=> !overflow_flag[4]) // R14
        else $error("transfer acknowledge did not clear overflow");
    a_set_wins: assert property (ovf_set[0] |=> overflow_flag[0] [*1]) // R17
        else $error("a same-cycle clear beat the overflow set");

endmodule

// ==== design/tsie_pkg.sv ====
// ----------------------------------------------------------------------------
// constants shared by the timer status and interrupt-enable block
// ----------------------------------------------------------------------------
// holds register offsets, field positions, reset values and counter codes.
// assumes an 8-bit register port and five timer channels on one clock.
package tsie_pkg;

    // ------------------------------------------------------------------------
    // structure
    // ------------------------------------------------------------------------
    localparam int NUM_CH = 5;
    localparam int DW = 8;
    localparam int AW = 8;
    localparam int CW = 16;

    // ------------------------------------------------------------------------
    // register offsets (one byte register per address)
    // ------------------------------------------------------------------------
    localparam logic [AW-1:0] OFS_STATUS = 8'h00;  // channel_status, ch0..ch4
    localparam logic [AW-1:0] OFS_ENABLE = 8'h08;  // irq enable, ch0..ch4
    localparam logic [AW-1:0] OFS_EVT_STAT = 8'h10;  // sticky event status, w1c
    localparam logic [AW-1:0] OFS_EVT_MASK = 8'h11;  // event mask

    // ------------------------------------------------------------------------
    // channel_status fields
    // ------------------------------------------------------------------------
    localparam int BIT_MATCH_A = 0;
    localparam int BIT_MATCH_B = 1;
    localparam int BIT_MATCH_C = 2;
    localparam int BIT_OVF = 4;
    localparam int BIT_UNF = 5;
    localparam int BIT_RSV6 = 6;
    localparam int BIT_DIR = 7;

    // ------------------------------------------------------------------------
    // event status / mask fields
    // ------------------------------------------------------------------------
    localparam int EVT_W = 7;
    localparam int EVT_OVF_LSB = 0;  // bits 4:0 overflow of ch0..ch4
    localparam int EVT_UNF1 = 5;
    localparam int EVT_UNF2 = 6;

    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic RST_DIR = 1'b1;
    localparam logic RST_RSV6 = 1'b1;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_ENABLE = 1'b0;
    localparam logic [EVT_W-1:0] RST_EVT = 7'h00;
    localparam logic [DW-1:0] RST_RDATA = 8'h00;

    // ------------------------------------------------------------------------
    // counter codes
    // ------------------------------------------------------------------------
    localparam logic [CW-1:0] CNT_MAX = 16'hffff;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CW-1:0] CNT_ONE = 16'h0001;

endpackage

// ==== design/tsie_flag.sv ====
// ----------------------------------------------------------------------------
// one status flag: set by an event, cleared by read-one-then-write-zero
// ----------------------------------------------------------------------------
// assumes rd and wr are the one-cycle strobes of its own status register,
// and that set and ack come from logic on the same clock.
module tsie_flag
    import tsie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set,
    input wire logic rd,
    input wire logic wr,
    input wire logic wbit,
    input wire logic ack_clr,
    output logic flag_ff
);

    logic armed_ff;

    // arming: a read that saw the flag high licenses the next write of zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_ff <= 1'b0;
        end else if (wr) begin
            armed_ff <= 1'b0;
        end else if (rd && flag_ff) begin
            armed_ff <= 1'b1;
        end
    end

    // flag: set wins over any clear in the same cycle so no event is lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag_ff <= RST_FLAG;
        end else if (set) begin // R17
            flag_ff <= 1'b1;
        end else if ((wr && armed_ff && !wbit) || ack_clr) begin
            flag_ff <= 1'b0;
        end
    end

endmodule

// ==== design/tsie_evt_irq.sv ====
// ----------------------------------------------------------------------------
// sticky event status, mask and single level interrupt
// ----------------------------------------------------------------------------
// assumes event pulses and register strobes on the same clock.
module tsie_evt_irq
    import tsie_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [EVT_W-1:0] evt,
    input wire logic wr_stat,
    input wire logic wr_mask,
    input wire logic [EVT_W-1:0] wdata,
    output logic [EVT_W-1:0] stat_ff,
    output logic [EVT_W-1:0] mask_ff,
    output logic irq_ff
);

    // status: write one to clear, a new event in the same cycle survives
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_ff <= RST_EVT;
        end else begin
            stat_ff <= (stat_ff & ~(wr_stat ? wdata : RST_EVT)) | evt; // R17
        end
    end

    // mask: plain read/write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_ff <= RST_EVT;
        end else if (wr_mask) begin
            mask_ff <= wdata;
        end
    end

    // level interrupt, registered so the output comes from a flip-flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

endmodule

// ==== bench/tsie_xfer_model.sv ====
// ----
// transfer controller stand-in
// ----
// answers the channel 4 overflow request; assumes the block's own clk
module tsie_xfer_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic overflow_irq,
    output logic xfer_ack_ovf
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_ff;
    // slow on purpose: one start every fourth cycle of a standing request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_ff <= 2'h0;
            xfer_ack_ovf <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 2'h1;
            xfer_ack_ovf <= go & overflow_irq & (cnt_ff == 2'h3);
        end
    end
endmodule

// ==== bench/tb_tsie_top.sv ====
// ----
// bench of the timer status block
// ----
// drives registers, events and counters; tsie_xfer_model plays the controller
module tb_tsie_top
    import tsie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, pwm = 1'b0, go = 1'b0, dis = 1'b0;
    logic ack, ovi, irq;
    logic [7:0] ad = 8'h00, wd = 8'h00, rdt;
    logic [2:1] pcm = 2'h3;
    logic [4:0] up = 5'h1f, ea = 5'h00, eb = 5'h00, ec = 5'h00, ia, ib, ic;
    logic [4:0][15:0] cnt = {5{16'h0100}};
    logic [7:0] fl [5], arm [5], en [5];
    logic [6:0] evs = 7'h00, evm = 7'h00;
    int n_errors = 0, checks_done = 0, seed = 76671;
    always #4 clk = ~clk;
    tsie_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s),
        .reg_rdata(rdt), .channel_counter(cnt), .count_up(up), .phase_count_mode(pcm), .cmp_pwm_mode(pwm),
        .match_a_event(ea), .match_b_event(eb), .match_c_event(ec), .xfer_ack_a(5'h00), .xfer_ack_b(5'h00),
        .xfer_ack_c(5'h00), .xfer_ack_ovf(ack), .transfer_clear_disable(dis), .match_a_irq(ia),
        .match_b_irq(ib), .match_c_irq(ic), .overflow_irq(ovi), .irq(irq));
    tsie_xfer_model u_xfer (.clk(clk), .rst_n(rst_n), .go(go), .overflow_irq(ovi), .xfer_ack_ovf(ack));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // modelled status: sticky flags plus the fixed and direction bits
    function automatic logic [7:0] st(input int c);
        return fl[c] | {c == 0 || up[c], 7'h40};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // reserved status bits are forced to their only legal write values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a < 8'h05) d = (d | 8'hc0) & (a == 8'h01 || a == 8'h02 ? 8'hff : 8'hdf);
        ad <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        if (a < 8'h05) fl[a] = fl[a] & ~(arm[a] & ~d);
        if (a < 8'h05) arm[a] = 8'h00;
        if (a[3]) en[a[2:0]] = d & (a == 8'h09 || a == 8'h0a ? 8'h03 : 8'h07);
        if (a == OFS_EVT_STAT) evs = evs & ~d[6:0];
        if (a == OFS_EVT_MASK) evm = d[6:0];
        // leave the edge's time step so a following call never re-raises the strobe in it
        #1;
    endtask
    // a read arms the clear of every bit it saw set
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        ad <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        if (a < 8'h05) arm[a] = e;
        #1 chk(rdt, e);
    endtask
    task automatic irqs;
        logic [4:0] xa, xb, xc;
        // look after the edge, where the registered requests have settled
        #1;
        for (int c = 0; c < 5; c++) begin
            xa[c] = fl[c][0] & en[c][0];
            xb[c] = fl[c][1] & en[c][1];
            xc[c] = fl[c][2] & en[c][2];
        end
        chk({3'h0, ia}, {3'h0, xa});
        chk({3'h0, ib}, {3'h0, xb});
        chk({3'h0, ic}, {3'h0, xc});
        chk({7'h0, irq}, {7'h0, |(evs & evm)});
        chk({7'h0, ovi}, {7'h0, fl[4][4] & evm[4]});
    endtask
    // counter steps a then b, then back to a value that wraps nowhere
    task automatic wrap(input int c, input logic [15:0] a, input logic [15:0] b);
        cnt[c] <= a;
        tick(1);
        cnt[c] <= b;
        tick(1);
        cnt[c] <= 16'h0100;
        tick(2);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    initial begin
        for (int c = 0; c < 5; c++) begin
            fl[c] = 8'h00;
            arm[c] = 8'h00;
            en[c] = 8'h00;
        end
        tick(20);
        rst_n <= 1'b1;
        up <= 5'($random(seed));
        tick(3);
        // idle values, random enables and one unmapped place
        for (int c = 0; c < 5; c++) begin
            rd(8'(c), st(c));
            wr(OFS_ENABLE + 8'(c), 8'($random(seed)));
            rd(OFS_ENABLE + 8'(c), en[c]);
        end
        rd(8'h20, 8'h00);
        ea <= 5'($random(seed));
        eb <= 5'($random(seed));
        ec <= 5'($random(seed));
        tick(1);
        for (int c = 0; c < 5; c++) begin
            fl[c] = fl[c] | {5'h0, ec[c] & c != 1 & c != 2, eb[c], ea[c]};
        end
        ea <= 5'h00;
        eb <= 5'h00;
        ec <= 5'h00;
        tick(2);
        irqs();
        // a zero clears only after a one was read; a one never clears
        for (int c = 0; c < 5; c++) begin
            wr(8'(c), 8'h00);
            rd(8'(c), st(c));
            wr(8'(c), 8'hff);
            wr(8'(c), 8'h00);
            rd(8'(c), st(c));
            wr(8'(c), 8'h00);
            rd(8'(c), st(c));
        end
        irqs();
        // set and clear in one cycle: the set wins
        ea <= 5'h01;
        wr(OFS_STATUS, 8'h00);
        ea <= 5'h00;
        fl[0][0] = 1'b1;
        rd(OFS_STATUS, st(0));
        ea <= 5'h01;
        wr(OFS_STATUS, 8'h00);
        ea <= 5'h00;
        fl[0][0] = 1'b1;
        rd(OFS_STATUS, st(0));
        // a step from 0001 to 0000 counts only in pwm mode
        wrap(4, 16'h0001, 16'h0000);
        rd(8'h04, st(4));
        pwm <= 1'b1;
        wrap(4, 16'h0001, 16'h0000);
        fl[4][4] = 1'b1;
        rd(8'h04, st(4));
        // outside phase counting mode a 0000 to ffff step is no underflow
        pcm <= 2'h0;
        wrap(1, 16'h0000, 16'hffff);
        rd(8'h01, st(1));
        pcm <= 2'h3;
        for (int c = 0; c < 5; c++) begin
            wrap(c, 16'hffff, 16'h0000);
            wrap(c, 16'h0000, 16'hffff);
            fl[c][4] = 1'b1;
            fl[c][5] = c == 1 || c == 2;
            rd(8'(c), st(c));
        end
        // a written one keeps a set underflow; read one then write zero clears
        wr(8'h01, 8'hff);
        rd(8'h01, st(1));
        rd(8'h02, st(2));
        wr(8'h02, 8'h00);
        rd(8'h02, st(2));
        evs = 7'h7f;
        irqs();
        wr(OFS_EVT_MASK, 8'h7f);
        tick(2);
        irqs();
        rd(OFS_EVT_STAT, {1'b0, evs});
        // controller starts: clear-disable 1 keeps the flag, 0 lets it clear
        dis <= 1'b1;
        go <= 1'b1;
        tick(12);
        rd(8'h04, st(4));
        dis <= 1'b0;
        tick(12);
        fl[4][4] = 1'b0;
        rd(8'h04, st(4));
        go <= 1'b0;
        wr(OFS_EVT_STAT, 8'h7f);
        tick(2);
        irqs();
        conclude();
    end
endmodule
